// file: bccb_chk.sv
/* assertions on bccb_top options and apb answer.
   assumes a bind to the ports of bccb_top. */
`default_nettype none
module bccb_chk (
    input wire logic pclk, presetn, psel, penable, pready, pslverr,
    input wire logic watchdog_default_off, watchdog_enable,
    input wire logic cycle_mode_sel, periph_clk_half, osc_gain_normal,
    input wire logic clk_filter_on, rc_div_bypass, clk_source_sel,
    input wire logic sysclk_rc_div2,
    input wire logic [3:0] osc_clks_per_cycle
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_WDT: assert property (watchdog_enable == !watchdog_default_off)
        else $error("wdt");
    AST_CYC: assert property (osc_clks_per_cycle ==
        (cycle_mode_sel ? 4'hc : 4'h6)) else $error("cycle");
    AST_HALF: assert property (periph_clk_half == cycle_mode_sel)
        else $error("half");
    AST_DIV: assert property (sysclk_rc_div2 ==
        (!clk_source_sel && !rc_div_bypass)) else $error("div");
    AST_HOLD: assert property ($past(presetn, 3) |-> $stable({
        watchdog_default_off, cycle_mode_sel, osc_gain_normal,
        clk_filter_on, rc_div_bypass, clk_source_sel})) else $error("hold");
    AST_ANS: assert property (psel && !penable ##1 psel && penable
        |-> pready) else $error("answer");
    AST_ONE: assert property (pready |=> !pready) else $error("one");
    AST_ERR: assert property (pslverr |-> pready) else $error("err");
    AST_ACC: assert property (pready |-> psel && penable) else $error("acc");
endmodule
bind bccb_top bccb_chk u_chk (.pclk, .presetn, .psel, .penable, .pready,
    .pslverr, .watchdog_default_off, .watchdog_enable, .cycle_mode_sel,
    .periph_clk_half, .osc_gain_normal, .clk_filter_on, .rc_div_bypass,
    .clk_source_sel, .sysclk_rc_div2, .osc_clks_per_cycle);
`default_nettype wire

// file: bccb_consts.vh
/*
 holds offsets, field positions and reset values of the boot clock
 configuration byte block.
 assumes it is included by bccb_top.v only.
*/
// Operation
// R01 - bit 7 at 1 keeps watchdog off after reset; at 0 it starts enabled
// R02 - cycle mode 1: 12 oscillator clocks per cycle, cpu clock half rate
// R03 - cycle mode 0: 6 oscillator clocks per cycle, cpu clock full rate
// R04 - bit 5 at 1 selects normal gain, at 0 reduced gain
// R05 - bit 4 at 1 inserts clock noise filter, at 0 bypasses it
// R06 - programmer should keep filter off above 24MHz crystals
// R07 - rc source with bit 3 at 1 uses the 22.1184MHz output directly
// R08 - rc source with bit 3 at 0 divides by two to 11.0592MHz
// R09 - bit 1 at 1 selects crystal or external clock, 0 internal rc
// R10 - erased byte reads all ones so every option defaults to 1
// R11 - programmer leaves reserved bits 2 and 0 unprogrammed
// R12 - byte copied into option latches at reset, held until next reset
// R13 - reserved bits have no effect and read back as programmed
`ifndef BCCB_CONSTS_VH
`define BCCB_CONSTS_VH
`define BCCB_ADDR_CFG        12'h000
`define BCCB_ADDR_STATUS     12'h004
`define BCCB_ADDR_PROG       12'h008
`define BCCB_ADDR_CMD        12'h00c
`define BCCB_CMD_PROG        8'ha5
`define BCCB_CMD_ERASE       8'h5a
`define BCCB_CFG_RESET       8'hff
`define BCCB_BIT_WDT_OFF     7
`define BCCB_BIT_CYCLE       6
`define BCCB_BIT_GAIN        5
`define BCCB_BIT_FILTER      4
`define BCCB_BIT_RC_BYPASS   3
`define BCCB_BIT_SOURCE      1
`define BCCB_CYC_LONG        4'hc
`define BCCB_CYC_SHORT       4'h6
`define BCCB_RST_WDT_OFF     1'b1
`define BCCB_RST_WDT_EN      1'b0
`define BCCB_RST_CYCLE       1'b1
`define BCCB_RST_HALF        1'b1
`define BCCB_RST_GAIN        1'b1
`define BCCB_RST_FILTER      1'b1
`define BCCB_RST_RC_BYPASS   1'b1
`define BCCB_RST_SOURCE      1'b1
`define BCCB_RST_RC_DIV2     1'b0
`define BCCB_RST_PRDATA      32'h0000_0000
`endif

// file: bccb_top.v
/*
 boot clock configuration byte: a non-volatile byte (erase and program
 over apb), latched into option outputs at each reset.
 assumes an apb master on pclk and that presetn models every device reset.
 the non-volatile cell keeps its value across presetn; its erased
 power-up state is the initial value of the cell register.
*/
`include "bccb_consts.vh"
`default_nettype none
module bccb_top
(
    // apb
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // option outputs
    output reg         watchdog_default_off,
    output reg         watchdog_enable,
    output reg         cycle_mode_sel,
    output reg  [3:0]  osc_clks_per_cycle,
    output reg         periph_clk_half,
    output reg         osc_gain_normal,
    output reg         clk_filter_on,
    output reg         rc_div_bypass,
    output reg         clk_source_sel,
    output reg         sysclk_rc_div2
);

    // register decode codes, one bit per mapped word
    localparam [3:0] HIT_NONE   = 4'h0;
    localparam [3:0] HIT_CFG    = 4'h1;
    localparam [3:0] HIT_STATUS = 4'h2;
    localparam [3:0] HIT_PROG   = 4'h4;
    localparam [3:0] HIT_CMD    = 4'h8;

    // non-volatile cell, erased at power-up
    reg [7:0]  clock_startup_config_byte = `BCCB_CFG_RESET; // R10
    reg [7:0]  prog_data;
    reg        loaded;
    reg [7:0]  opt;
    reg [31:0] next_prdata;
    reg        next_err;
    wire [3:0] hit;
    wire       setup;
    wire       xfer;
    wire       wr;
    wire       cmd_erase;
    wire       cmd_program;
    wire       prog_load;

    // maps a byte address to its one-hot register code
    function [3:0] bccb_decode;
        input [11:0] addr;
        begin
            case (addr)
                `BCCB_ADDR_CFG:
                    bccb_decode = HIT_CFG;
                `BCCB_ADDR_STATUS:
                    bccb_decode = HIT_STATUS;
                `BCCB_ADDR_PROG:
                    bccb_decode = HIT_PROG;
                `BCCB_ADDR_CMD:
                    bccb_decode = HIT_CMD;
                default:
                    bccb_decode = HIT_NONE;
            endcase
        end
    endfunction

    // tells whether a command word carries a given command code
    function bccb_is_cmd;
        input [31:0] data;
        input [7:0]  code;
        begin
            bccb_is_cmd = (data[7:0] == code);
        end
    endfunction

    assign hit         = bccb_decode(paddr);
    assign setup       = psel & ~penable;
    // a write lands only at the edge where pready is seen high
    assign xfer        = psel & penable & pready;
    assign wr          = xfer & pwrite;
    assign cmd_erase   = wr & (hit == HIT_CMD)
                         & bccb_is_cmd(pwdata, `BCCB_CMD_ERASE);
    assign cmd_program = wr & (hit == HIT_CMD)
                         & bccb_is_cmd(pwdata, `BCCB_CMD_PROG);
    assign prog_load   = wr & (hit == HIT_PROG);

    // non-volatile byte: erase sets all bits, programming clears only
    always @(posedge pclk)
    begin
        if (cmd_erase)
        begin
            clock_startup_config_byte <= `BCCB_CFG_RESET; // R10
        end
        else if (cmd_program)
        begin
            clock_startup_config_byte <= clock_startup_config_byte
                                         & prog_data; // R13
        end
    end

    // program data word, only its low byte is kept
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prog_data <= `BCCB_CFG_RESET;
        end
        else if (prog_load)
        begin
            prog_data <= pwdata[7:0];
        end
    end

    // marks the first edge after reset release
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            loaded <= 1'b0;
        end
        else
        begin
            loaded <= 1'b1;
        end
    end

    // option latches: copied once after each reset release, then held
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            opt <= `BCCB_CFG_RESET; // R10
        end
        else if (!loaded)
        begin
            opt <= clock_startup_config_byte; // R12
        end
    end

    // option outputs, each straight from its own flip-flop
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            watchdog_default_off <= `BCCB_RST_WDT_OFF;
        end
        else
        begin
            watchdog_default_off <= opt[`BCCB_BIT_WDT_OFF]; // R01
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            watchdog_enable <= `BCCB_RST_WDT_EN;
        end
        else
        begin
            watchdog_enable <= ~opt[`BCCB_BIT_WDT_OFF]; // R01
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cycle_mode_sel <= `BCCB_RST_CYCLE;
        end
        else
        begin
            cycle_mode_sel <= opt[`BCCB_BIT_CYCLE]; // R02 R03
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osc_clks_per_cycle <= `BCCB_CYC_LONG;
        end
        else
        begin
            osc_clks_per_cycle <= opt[`BCCB_BIT_CYCLE]
                                  ? `BCCB_CYC_LONG // R02
                                  : `BCCB_CYC_SHORT; // R03
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            periph_clk_half <= `BCCB_RST_HALF;
        end
        else
        begin
            periph_clk_half <= opt[`BCCB_BIT_CYCLE]; // R02 R03
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osc_gain_normal <= `BCCB_RST_GAIN;
        end
        else
        begin
            osc_gain_normal <= opt[`BCCB_BIT_GAIN]; // R04
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clk_filter_on <= `BCCB_RST_FILTER;
        end
        else
        begin
            clk_filter_on <= opt[`BCCB_BIT_FILTER]; // R05
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rc_div_bypass <= `BCCB_RST_RC_BYPASS;
        end
        else
        begin
            rc_div_bypass <= opt[`BCCB_BIT_RC_BYPASS]; // R07
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clk_source_sel <= `BCCB_RST_SOURCE;
        end
        else
        begin
            clk_source_sel <= opt[`BCCB_BIT_SOURCE]; // R09
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sysclk_rc_div2 <= `BCCB_RST_RC_DIV2;
        end
        else
        begin
            sysclk_rc_div2 <= ~opt[`BCCB_BIT_SOURCE]
                              & ~opt[`BCCB_BIT_RC_BYPASS]; // R08
        end
    end

    // read mux and unmapped-address error
    always @*
    begin
        next_prdata = 32'h0000_0000;
        next_err    = 1'b0;
        case (hit)
            HIT_CFG:
                next_prdata = {24'h000000, clock_startup_config_byte}; // R13
            HIT_STATUS:
                next_prdata = {24'h000000, opt};
            HIT_PROG:
                next_prdata = {24'h000000, prog_data};
            HIT_CMD:
                next_prdata = 32'h0000_0000;
            default:
                next_err    = 1'b1;
        endcase
    end

    // no wait state: pready rises in the first access cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
        end
        else
        begin
            pready <= setup;
        end
    end

    // error answer goes with pready
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pslverr <= 1'b0;
        end
        else
        begin
            pslverr <= setup & next_err;
        end
    end

    // read data captured at setup, stands until the next read
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= `BCCB_RST_PRDATA;
        end
        else if (setup && !pwrite)
        begin
            prdata <= next_prdata;
        end
    end

endmodule
`default_nettype wire

// file: test_boot_clock_config_byte.sv
/* random bench for bccb_top: programs the byte, resets, checks options.
   assumes the block alone on pclk. */
`default_nettype none
module test_boot_clock_config_byte;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, er, watchdog_default_off, watchdog_enable;
    logic cycle_mode_sel, periph_clk_half, osc_gain_normal, clk_filter_on;
    logic rc_div_bypass, clk_source_sel, sysclk_rc_div2;
    logic [3:0] osc_clks_per_cycle;
    logic [7:0] b, p, q;
    int mismatches = 0, checks = 0, cyc = 0;
    wire logic [12:0] seen = {watchdog_default_off, watchdog_enable,
        cycle_mode_sel, osc_clks_per_cycle, periph_clk_half,
        osc_gain_normal, clk_filter_on, rc_div_bypass, clk_source_sel,
        sysclk_rc_div2};
    always #50 pclk = ~pclk;
    bccb_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .watchdog_default_off,
        .watchdog_enable, .cycle_mode_sel, .osc_clks_per_cycle,
        .periph_clk_half, .osc_gain_normal, .clk_filter_on,
        .rc_div_bypass, .clk_source_sel, .sysclk_rc_div2);
    function logic [12:0] opt(input logic [7:0] v);
        return {v[7], ~v[7], v[6], v[6] ? 4'hc : 4'h6, v[6], v[5], v[4],
            v[3], v[1], ~v[1] & ~v[3]};
    endfunction
    task chk(input logic [31:0] e, s, input string n);
        checks++;
        if (e !== s)
        begin
            mismatches++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1 && cyc < 2000);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            mismatches++;
            finish_test;
        end
    end
    initial
    begin
        void'($urandom(35));
        repeat (4) @(posedge pclk);
        presetn <= 1;
        repeat (2) @(posedge pclk);
        p = 8'hff;
        for (int i = 0; i < 10; i++)
        begin
            chk(opt(p), seen, "opts");
            b = i == 0 ? 8'h05 : i == 1 ? 8'h0d : 8'($urandom) | 8'h05;
            q = i < 2 ? 8'hff : 8'($urandom) | 8'h05;
            if (b[5]) b[4] = 1'b0;
            apb(1, 12'h00c, 32'h5a);
            apb(0, 12'h000, 0);
            chk(32'hff, rd, "erased");
            apb(1, 12'h008, {24'h0, b});
            apb(0, 12'h008, 0);
            chk({24'h0, b}, rd, "progdata");
            apb(1, 12'h00c, 32'ha5);
            apb(1, 12'h008, {24'h0, q});
            apb(1, 12'h00c, 32'ha5);
            apb(1, 12'h000, 0);
            apb(0, 12'h000, 0);
            chk({24'h0, b & q}, rd, "cleared");
            apb(0, 12'h004, 0);
            chk({24'h0, p}, rd, "status");
            chk(0, er, "okay");
            chk(opt(p), seen, "held");
            b = b & q;
            presetn <= 0;
            @(posedge pclk) presetn <= 1;
            repeat (2) @(posedge pclk);
            apb(0, 12'h000, 0);
            chk({24'h0, b}, rd, "byte");
            p = b;
        end
        apb(0, 12'h010, 0);
        chk(1, er, "unmapped");
        finish_test;
    end
endmodule
`default_nettype wire
